// File: spi_rx_defines.svh
// Purpose: Register offsets, field positions, reset values and codes of the receive status block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by bare name; definitions only.
`ifndef SPI_RX_DEFINES_SVH
`define SPI_RX_DEFINES_SVH

// Byte offsets of the registers.
`define LEVEL_SEL_OFFSET  8'h00
`define FLAG_OFFSET       8'h04
`define BUFFER_OFFSET     8'h08
`define MASK_OFFSET       8'h0C
`define VECTOR0_OFFSET    8'h10
`define VECTOR1_OFFSET    8'h14

// Bit positions shared by flag, mask and level-select registers.
`define FULL_BIT          0
`define OVERRUN_BIT       1
`define BIT_ERROR_BIT     2
`define FLAG_COUNT        3

// Field positions inside the receive buffer register.
`define DATA_LSB          0
`define STATUS_LSB        16

// Reset values.
`define MASK_RESET        3'h0
`define LEVEL_RESET       3'h0
`define DATA_RESET        16'h0000

// Vector codes, highest priority first.
`define VECTOR_W          5
`define VEC_NONE          5'h00
`define VEC_BIT_ERROR     5'h01
`define VEC_OVERRUN       5'h02
`define VEC_FULL          5'h03

`endif

// File: spi_rx_pkg.sv
// Purpose: Types shared by the receive status block and its helpers.
// Assumes: Nothing beyond the defines header.
// Notes:   State of each module is one packed struct.
`include "spi_rx_defines.svh"
package spi_rx_pkg;

  typedef struct packed {
    logic [`FLAG_COUNT-1:0] flags;
  } flag_state_type;

  typedef struct packed {
    logic [`VECTOR_W-1:0]   code;
    logic [`FLAG_COUNT-1:0] onehot;
  } vector_state_type;

  typedef struct packed {
    logic [2:0]             sync;
    logic                   suspended;
    logic [15:0]            data;
    logic [`FLAG_COUNT-1:0] level;
    logic [`FLAG_COUNT-1:0] mask;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   slverr;
    logic [`FLAG_COUNT-1:0] read_clear;
    logic                   irq0;
    logic                   irq1;
    logic                   irq;
  } top_state_type;

endpackage

// File: spi_rx_status.sv
// Purpose: Receive status flags, receive buffer and two-level interrupt vectors of a serial port.
// Assumes: Shifter events arrive on pclk; the suspend level comes from outside the domain.
// Notes:   APB slave with zero wait states beyond one registered ready cycle.
`timescale 1ns/10ps
`include "spi_rx_defines.svh"

module spi_rx_status #(
  parameter int DATA_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_done,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic              bit_error_event,
  input  wire logic              debug_suspend,
  output logic                   overrun_interrupt,
  output logic                   bit_error_interrupt,
  output logic                   irq_level0,
  output logic                   irq_level1,
  output logic                   irq
);
  spi_rx_pkg::top_state_type state_q;
  spi_rx_pkg::top_state_type state_d;

  logic [`FLAG_COUNT-1:0] flags;
  logic [`FLAG_COUNT-1:0] flag_set;
  logic [`FLAG_COUNT-1:0] flag_clr;
  logic [`FLAG_COUNT-1:0] pend0;
  logic [`FLAG_COUNT-1:0] pend1;
  logic [`VECTOR_W-1:0]   vec0_code;
  logic [`VECTOR_W-1:0]   vec1_code;
  logic [`FLAG_COUNT-1:0] vec0_onehot;
  logic [`FLAG_COUNT-1:0] vec1_onehot;
  logic                   setup;
  logic                   access;
  logic                   wr_access;
  logic                   buf_read_access;
  logic                   overrun_event;
  logic                   mapped;
  logic [31:0]            read_mux;
  logic [`FLAG_COUNT-1:0] read_cand;

  // Bus phases; a transfer completes at the edge where pready is seen high.
  assign setup     = psel & ~penable;
  assign access    = psel & penable & state_q.ready;
  assign wr_access = access & pwrite;
  assign buf_read_access = access & ~pwrite & (paddr == `BUFFER_OFFSET);

  // A word completing while the previous one is unread is an overrun, unless that
  // same edge completes a buffer read.
  assign overrun_event = rx_done & flags[`FULL_BIT] & ~buf_read_access;

  // Hardware set terms for the sticky flags.
  always_comb begin
    flag_set                 = '0;
    flag_set[`FULL_BIT]      = rx_done;
    flag_set[`OVERRUN_BIT]   = overrun_event;
    flag_set[`BIT_ERROR_BIT] = bit_error_event;
  end

  // Clear terms: read-to-clear snapshots and write-one-to-clear of the error flags.
  // Read clears come only from bits that were visible in the returned data, so an
  // event landing during the transfer is never swallowed; the flag bank lets sets win.
  always_comb begin
    flag_clr = '0;
    if (access && !pwrite) begin
      flag_clr = state_q.read_clear;
    end
    if (wr_access && paddr == `FLAG_OFFSET) begin
      flag_clr[`OVERRUN_BIT]   = flag_clr[`OVERRUN_BIT] | pwdata[`OVERRUN_BIT];
      flag_clr[`BIT_ERROR_BIT] = flag_clr[`BIT_ERROR_BIT] | pwdata[`BIT_ERROR_BIT];
    end
  end

  sticky_flags flag_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (flag_set),
    .clr     (flag_clr),
    .flags   (flags)
  );

  // Enabled sources routed to the level that software selected.
  assign pend0 = flags & state_q.mask & ~state_q.level;
  assign pend1 = flags & state_q.mask & state_q.level;

  vector_encoder level0_vector (
    .pclk    (pclk),
    .presetn (presetn),
    .pending (pend0),
    .code    (vec0_code),
    .onehot  (vec0_onehot)
  );

  vector_encoder level1_vector (
    .pclk    (pclk),
    .presetn (presetn),
    .pending (pend1),
    .code    (vec1_code),
    .onehot  (vec1_onehot)
  );

  // Read data and the flags that the read would clear, chosen at the setup cycle.
  always_comb begin
    read_mux  = '0;
    read_cand = '0;
    mapped    = 1'b1;
    unique case (paddr)
      `LEVEL_SEL_OFFSET: begin
        read_mux[`FLAG_COUNT-1:0] = state_q.level;
      end
      `FLAG_OFFSET: begin
        read_mux[`FLAG_COUNT-1:0]  = flags;
        read_cand[`OVERRUN_BIT]    = flags[`OVERRUN_BIT];
        read_cand[`BIT_ERROR_BIT]  = flags[`BIT_ERROR_BIT];
      end
      `BUFFER_OFFSET: begin
        read_mux[`DATA_LSB +: DATA_W]       = state_q.data;
        read_mux[`STATUS_LSB +: `FLAG_COUNT] = flags;
        read_cand[`FULL_BIT]                = flags[`FULL_BIT];
      end
      `MASK_OFFSET: begin
        read_mux[`FLAG_COUNT-1:0] = state_q.mask;
      end
      `VECTOR0_OFFSET: begin
        read_mux[`VECTOR_W-1:0] = vec0_code;
        read_cand               = vec0_onehot;
      end
      `VECTOR1_OFFSET: begin
        read_mux[`VECTOR_W-1:0] = vec1_code;
        read_cand               = vec1_onehot;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Next state of the bus slave, registers, suspend synchroniser and interrupts.
  always_comb begin
    state_d = state_q;
    // Suspend passes three flops; a change counts once the last two agree.
    state_d.sync = {state_q.sync[1:0], debug_suspend};
    if (state_q.sync[1] == state_q.sync[2]) begin
      state_d.suspended = state_q.sync[2];
    end
    // Ready rises for exactly one cycle after each setup cycle.
    state_d.ready  = setup;
    state_d.slverr = setup & ~mapped;
    if (setup) begin
      state_d.rdata = pwrite ? 32'h0000_0000 : read_mux;
      // A debugger read leaves every flag alone; a set at this edge is also excluded.
      if (state_q.suspended || pwrite) begin
        state_d.read_clear = '0;
      end else begin
        state_d.read_clear = read_cand & ~flag_set;
      end
    end
    // New data always replaces the buffer, overrun or not.
    if (rx_done) begin
      state_d.data = rx_data;
    end
    // Software writes to the control registers.
    if (wr_access) begin
      if (paddr == `LEVEL_SEL_OFFSET) begin
        state_d.level = pwdata[`FLAG_COUNT-1:0];
      end
      if (paddr == `MASK_OFFSET) begin
        state_d.mask = pwdata[`FLAG_COUNT-1:0];
      end
    end
    // Level interrupt outputs follow the enabled pending flags.
    state_d.irq0 = |pend0;
    state_d.irq1 = |pend1;
    state_d.irq  = |(flags & state_q.mask);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= '0;
      state_q.mask  <= `MASK_RESET;
      state_q.level <= `LEVEL_RESET;
      state_q.data  <= `DATA_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops.
  assign prdata              = state_q.rdata;
  assign pready              = state_q.ready;
  assign pslverr             = state_q.slverr;
  assign overrun_interrupt   = flags[`OVERRUN_BIT];
  assign bit_error_interrupt = flags[`BIT_ERROR_BIT];
  assign irq_level0          = state_q.irq0;
  assign irq_level1          = state_q.irq1;
  assign irq                 = state_q.irq;

  // Receive full is set on every completed word.
  chk_full_sets: assert property (
    @(posedge pclk) disable iff (!presetn) rx_done |=> flags[`FULL_BIT])
    else $error("receive full not set after word");

  // A bit error is kept whatever read coincides with it.
  chk_bit_error_kept: assert property (
    @(posedge pclk) disable iff (!presetn) bit_error_event |=> flags[`BIT_ERROR_BIT])
    else $error("bit error flag lost");

  // Overrun sets on a word arriving while full, unless a buffer read completes at that edge.
  chk_overrun_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
      (rx_done && flags[`FULL_BIT] && !buf_read_access) |=> flags[`OVERRUN_BIT])
    else $error("overrun flag lost");

  // A buffer read meeting a bit error keeps the bit error flag.
  chk_buffer_read_safe: assert property (
    @(posedge pclk) disable iff (!presetn)
      (buf_read_access && bit_error_event) |=> flags[`BIT_ERROR_BIT])
    else $error("buffer read lost bit error");

  // Writing one to overrun clears it when no new overrun arrives.
  chk_overrun_w1c: assert property (
    @(posedge pclk) disable iff (!presetn)
      (wr_access && paddr == `FLAG_OFFSET && pwdata[`OVERRUN_BIT] && !overrun_event)
      |=> !flags[`OVERRUN_BIT])
    else $error("overrun not cleared by write");

  // A normal buffer read with no arrival around it empties the buffer.
  chk_buffer_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
      (buf_read_access && !rx_done && !$past(rx_done) && !$past(state_q.suspended))
      |=> !flags[`FULL_BIT])
    else $error("receive full not cleared by read");

  // A suspended read of the flag register leaves overrun set.
  chk_debug_read: assert property (
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `FLAG_OFFSET && state_q.suspended && flags[`OVERRUN_BIT])
      ##1 (access && !(pwrite && pwdata[`OVERRUN_BIT])) |=> flags[`OVERRUN_BIT])
    else $error("debug read cleared a flag");

  // A pending level zero source shows in its vector one edge later.
  chk_vector_level0: assert property (
    @(posedge pclk) disable iff (!presetn) (pend0 != '0) |=> (vec0_code != `VEC_NONE))
    else $error("level zero vector empty while pending");

  // Ready is a single-cycle answer to each setup cycle.
  chk_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn) setup |=> pready ##1 !pready)
    else $error("ready not a single pulse");

  // Writing one to bit error clears it when no new bit error arrives.
  chk_bit_error_w1c: assert property (
    @(posedge pclk) disable iff (!presetn)
      (wr_access && paddr == `FLAG_OFFSET && pwdata[`BIT_ERROR_BIT] && !bit_error_event)
      |=> !flags[`BIT_ERROR_BIT])
    else $error("bit error not cleared by write");

  // An overrun clear landing while receive full sets still clears overrun.
  chk_overrun_clear_race: assert property (
    @(posedge pclk) disable iff (!presetn)
      (wr_access && paddr == `FLAG_OFFSET && pwdata[`OVERRUN_BIT] && rx_done
       && !flags[`FULL_BIT])
      |=> (flags[`FULL_BIT] && !flags[`OVERRUN_BIT]))
    else $error("overrun clear lost against receive full");

  // Level one line follows its enabled pending sources one edge later.
  chk_irq_level1: assert property (
    @(posedge pclk) disable iff (!presetn) (pend1 != '0) |=> irq_level1)
    else $error("level one interrupt missing");

  // A level zero line never rises without a level zero source.
  chk_level_split: assert property (
    @(posedge pclk) disable iff (!presetn) (pend0 == '0) |=> !irq_level0)
    else $error("level zero interrupt without a source");

  // With every source masked off the combined line stays low.
  chk_irq_masked: assert property (
    @(posedge pclk) disable iff (!presetn) ((flags & state_q.mask) == '0) |=> !irq)
    else $error("interrupt high with nothing enabled");

  // A pending level one source shows in its vector one edge later.
  chk_vector_level1: assert property (
    @(posedge pclk) disable iff (!presetn) (pend1 != '0) |=> (vec1_code != `VEC_NONE))
    else $error("level one vector empty while pending");

  // Every completed word replaces the buffer, overrun or not.
  chk_data_replaced: assert property (
    @(posedge pclk) disable iff (!presetn) rx_done |=> (state_q.data == $past(rx_data)))
    else $error("buffer not replaced by new word");

  // A read set up while suspended schedules no clear at all.
  chk_debug_no_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
      (setup && state_q.suspended) |=> (state_q.read_clear == '0))
    else $error("debug read scheduled a clear");

  // A buffer read meeting a new word keeps receive full and raises no overrun.
  chk_read_race: assert property (
    @(posedge pclk) disable iff (!presetn)
      (buf_read_access && rx_done && !flags[`OVERRUN_BIT])
      |=> (flags[`FULL_BIT] && !flags[`OVERRUN_BIT]))
    else $error("read race lost receive full");

  // Received data is returned in the low half of a buffer read.
  chk_data_low_half: assert property (
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `BUFFER_OFFSET)
      |=> (prdata[DATA_W-1:0] == $past(state_q.data)))
    else $error("buffer data not in low half");

  // An error response only ever comes together with ready.
  chk_error_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn) pslverr |-> pready)
    else $error("error response without ready");

  // Main scenarios.
  cov_overrun: cover property (@(posedge pclk) disable iff (!presetn) overrun_event);
  cov_read_race: cover property (@(posedge pclk) disable iff (!presetn) buf_read_access && rx_done);
  cov_debug_read: cover property (
    @(posedge pclk) disable iff (!presetn) access && !pwrite && state_q.suspended);
  cov_level1_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_level1);
  cov_write_race: cover property (
    @(posedge pclk) disable iff (!presetn) wr_access && rx_done);
endmodule

// File: sticky_flags.sv
// Purpose: Bank of sticky flags where a set in the same cycle as a clear wins.
// Assumes: Set and clear come from logic on pclk.
// Notes:   One loop builds every flag.
`timescale 1ns/10ps
`include "spi_rx_defines.svh"
module sticky_flags (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [`FLAG_COUNT-1:0] set,
  input  wire logic [`FLAG_COUNT-1:0] clr,
  output logic      [`FLAG_COUNT-1:0] flags
);
  spi_rx_pkg::flag_state_type state_q;
  spi_rx_pkg::flag_state_type state_d;

  // Each flag keeps its value, is cleared on request, and a set overrides the clear.
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < `FLAG_COUNT; i++) begin
      state_d.flags[i] = (state_q.flags[i] & ~clr[i]) | set[i];
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.flags;
endmodule

// File: test_spi_rx_status.sv
// Purpose: Self-checking bench for the receive status block over APB.
// Assumes: The slave raises pready in the access cycle; shifter events are pclk pulses.
// Notes:   Table rows cover register access; hand tests cover races, debug and reset.
`timescale 1ns/10ps
`include "spi_rx_defines.svh"
module test_spi_rx_status;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } row_type;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_done = 1'b0;
  logic [15:0] rx_data = 16'h0000;
  logic        bit_error_event = 1'b0;
  logic        debug_suspend = 1'b0;
  logic        overrun_interrupt;
  logic        bit_error_interrupt;
  logic        irq_level0;
  logic        irq_level1;
  logic        irq;
  int          n_errors = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  logic        er;
  row_type     rows [14];

  // The block under test.
  spi_rx_status #(.DATA_W(16)) spi_rx_status_i (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .rx_done             (rx_done),
    .rx_data             (rx_data),
    .bit_error_event     (bit_error_event),
    .debug_suspend       (debug_suspend),
    .overrun_interrupt   (overrun_interrupt),
    .bit_error_interrupt (bit_error_interrupt),
    .irq_level0          (irq_level0),
    .irq_level1          (irq_level1),
    .irq                 (irq)
  );

  // The clock toggles every half period of 5 ns.
  always #5 pclk = ~pclk;

  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; optional event pulses land on the setup edge (early) or the access edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     input logic rx, input logic be, input logic early,
                     output logic [31:0] data, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    if (early) begin
      rx_done <= rx;
      bit_error_event <= be;
    end
    @(posedge pclk);
    penable <= 1'b1;
    rx_done <= early ? 1'b0 : rx;
    bit_error_event <= early ? 1'b0 : be;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check_bit(pready, 1'b1);
    data = prdata;
    err = pslverr;
    rx_done <= 1'b0;
    bit_error_event <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] d);
    apb(1'b1, addr, d, 1'b0, 1'b0, 1'b0, rd, er);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h00000000, 1'b0, 1'b0, 1'b0, rd, er);
    check_word(rd, exp);
  endtask

  // Shifter event pulse lasting exactly one cycle.
  task automatic pulse(input logic rx, input logic be, input logic [15:0] d);
    @(posedge pclk);
    rx_data <= d;
    rx_done <= rx;
    bit_error_event <= be;
    @(posedge pclk);
    rx_done <= 1'b0;
    bit_error_event <= 1'b0;
  endtask

  // Watchdog cuts a hang short well beyond the expected run length.
  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  // Main sequence: table of register accesses, then hand-written races.
  initial begin
    rows[0]  = '{1'b0, `MASK_OFFSET, 32'h0, 32'h0, 1'b0};
    rows[1]  = '{1'b0, `LEVEL_SEL_OFFSET, 32'h0, 32'h0, 1'b0};
    rows[2]  = '{1'b0, `FLAG_OFFSET, 32'h0, 32'h0, 1'b0};
    rows[3]  = '{1'b0, `BUFFER_OFFSET, 32'h0, 32'h0, 1'b0};
    rows[4]  = '{1'b0, `VECTOR0_OFFSET, 32'h0, 32'h0, 1'b0};
    rows[5]  = '{1'b0, `VECTOR1_OFFSET, 32'h0, 32'h0, 1'b0};
    rows[6]  = '{1'b1, `MASK_OFFSET, 32'hFFFFFFFF, 32'h0, 1'b0};
    rows[7]  = '{1'b0, `MASK_OFFSET, 32'h0, 32'h7, 1'b0};
    rows[8]  = '{1'b1, `LEVEL_SEL_OFFSET, 32'h6, 32'h0, 1'b0};
    rows[9]  = '{1'b0, `LEVEL_SEL_OFFSET, 32'h0, 32'h6, 1'b0};
    rows[10] = '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1};
    rows[11] = '{1'b1, 8'h18, 32'hFFFFFFFF, 32'h0, 1'b1};
    rows[12] = '{1'b1, `VECTOR0_OFFSET, 32'hFFFFFFFF, 32'h0, 1'b0};
    rows[13] = '{1'b0, `VECTOR0_OFFSET, 32'h0, 32'h0, 1'b0};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, 1'b0, 1'b0, 1'b0, rd, er);
      check_word(rd, rows[i].exp);
      check_bit(er, rows[i].err);
    end
    // Receive full routes to level zero, data sits in the low half.
    pulse(1'b1, 1'b0, 16'h1234);
    idle(2);
    check_bit(irq_level0, 1'b1);
    check_bit(irq_level1, 1'b0);
    rd_chk(`BUFFER_OFFSET, 32'h00011234);
    rd_chk(`FLAG_OFFSET, 32'h00000000);
    // Two words without service raise overrun on level one.
    pulse(1'b1, 1'b0, 16'h1111);
    pulse(1'b1, 1'b0, 16'h2222);
    idle(2);
    check_bit(overrun_interrupt, 1'b1);
    check_bit(irq_level1, 1'b1);
    rd_chk(`BUFFER_OFFSET, 32'h00032222);
    rd_chk(`VECTOR1_OFFSET, {27'h0, `VEC_OVERRUN});
    rd_chk(`FLAG_OFFSET, 32'h00000000);
    // Both error events land on the access edge of a flag read.
    pulse(1'b1, 1'b0, 16'h3333);
    apb(1'b0, `FLAG_OFFSET, 32'h0, 1'b1, 1'b1, 1'b0, rd, er);
    check_word(rd, 32'h00000001);
    idle(1);
    check_bit(overrun_interrupt, 1'b1);
    check_bit(bit_error_interrupt, 1'b1);
    // A bit error landing on the edge where a flag read clears it survives.
    apb(1'b0, `FLAG_OFFSET, 32'h0, 1'b0, 1'b1, 1'b0, rd, er);
    check_word(rd, 32'h00000007);
    rd_chk(`FLAG_OFFSET, 32'h00000005);
    rd_chk(`FLAG_OFFSET, 32'h00000001);
    // Overrun at the setup edge of a buffer read, bit error at the access edge of another.
    rx_data <= 16'h5555;
    apb(1'b0, `BUFFER_OFFSET, 32'h0, 1'b1, 1'b0, 1'b1, rd, er);
    check_word(rd, 32'h00013333);
    idle(1);
    check_bit(overrun_interrupt, 1'b1);
    apb(1'b0, `BUFFER_OFFSET, 32'h0, 1'b0, 1'b1, 1'b0, rd, er);
    check_word(rd, 32'h00035555);
    idle(1);
    check_bit(bit_error_interrupt, 1'b1);
    wr(`FLAG_OFFSET, 32'h00000004);
    // Overrun clear coincides with receive full being set.
    rx_data <= 16'h6666;
    apb(1'b1, `FLAG_OFFSET, 32'h2, 1'b1, 1'b0, 1'b0, rd, er);
    idle(1);
    check_bit(overrun_interrupt, 1'b0);
    rd_chk(`FLAG_OFFSET, 32'h00000001);
    // Buffer read coincides with a new word: full stays set, no overrun.
    rx_data <= 16'h7777;
    apb(1'b0, `BUFFER_OFFSET, 32'h0, 1'b1, 1'b0, 1'b0, rd, er);
    check_word(rd, 32'h00016666);
    idle(1);
    check_bit(overrun_interrupt, 1'b0);
    rd_chk(`FLAG_OFFSET, 32'h00000001);
    rd_chk(`BUFFER_OFFSET, 32'h00017777);
    // Reads during debug suspend leave the flags alone.
    debug_suspend <= 1'b1;
    idle(6);
    pulse(1'b1, 1'b1, 16'h9999);
    pulse(1'b1, 1'b0, 16'hAAAA);
    rd_chk(`FLAG_OFFSET, 32'h00000007);
    rd_chk(`FLAG_OFFSET, 32'h00000007);
    rd_chk(`BUFFER_OFFSET, 32'h0007AAAA);
    rd_chk(`VECTOR1_OFFSET, {27'h0, `VEC_BIT_ERROR});
    rd_chk(`VECTOR1_OFFSET, {27'h0, `VEC_BIT_ERROR});
    debug_suspend <= 1'b0;
    idle(6);
    rd_chk(`FLAG_OFFSET, 32'h00000007);
    rd_chk(`BUFFER_OFFSET, 32'h0001AAAA);
    rd_chk(`FLAG_OFFSET, 32'h00000000);
    // Mask gates the interrupt; moving the source to level zero moves the line.
    pulse(1'b0, 1'b1, 16'h0000);
    wr(`MASK_OFFSET, 32'h00000000);
    idle(2);
    check_bit(irq, 1'b0);
    check_bit(bit_error_interrupt, 1'b1);
    wr(`LEVEL_SEL_OFFSET, 32'h00000000);
    wr(`MASK_OFFSET, 32'h00000007);
    idle(2);
    check_bit(irq_level0, 1'b1);
    check_bit(irq_level1, 1'b0);
    wr(`FLAG_OFFSET, 32'h00000004);
    idle(2);
    check_bit(irq, 1'b0);
    // A second reset in mid-run returns everything to its reset value.
    pulse(1'b1, 1'b0, 16'h8888);
    presetn <= 1'b0;
    idle(2);
    check_bit(irq, 1'b0);
    presetn <= 1'b1;
    rd_chk(`MASK_OFFSET, 32'h00000000);
    rd_chk(`BUFFER_OFFSET, 32'h00000000);
    summarize();
  end
endmodule

// File: vector_encoder.sv
// Purpose: Registered priority encoder giving the vector of one interrupt level.
// Assumes: Pending bits already filtered by mask and level.
// Notes:   Bit error outranks overrun, overrun outranks receive full.
`timescale 1ns/10ps
`include "spi_rx_defines.svh"
module vector_encoder (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [`FLAG_COUNT-1:0] pending,
  output logic      [`VECTOR_W-1:0]   code,
  output logic      [`FLAG_COUNT-1:0] onehot
);
  spi_rx_pkg::vector_state_type state_q;
  spi_rx_pkg::vector_state_type state_d;

  // Pick the highest priority pending source and its one-hot select.
  always_comb begin
    state_d = '0;
    if (pending[`BIT_ERROR_BIT]) begin
      state_d.code                  = `VEC_BIT_ERROR;
      state_d.onehot[`BIT_ERROR_BIT] = 1'b1;
    end else if (pending[`OVERRUN_BIT]) begin
      state_d.code                = `VEC_OVERRUN;
      state_d.onehot[`OVERRUN_BIT] = 1'b1;
    end else if (pending[`FULL_BIT]) begin
      state_d.code             = `VEC_FULL;
      state_d.onehot[`FULL_BIT] = 1'b1;
    end else begin
      state_d.code = `VEC_NONE;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign code   = state_q.code;
  assign onehot = state_q.onehot;
endmodule
